//--- core/spt_pkg.sv
`default_nettype none
package spt_pkg;
   localparam int SPT_ADDR_W = 4;
   localparam int SPT_DATA_W = 8;
   localparam int SPT_RATE_W = 3;
   // register map
   localparam logic [3:0] SPT_ADDR_OPTION = 4'h0;
   localparam logic [3:0] SPT_ADDR_INTCTL = 4'h1;
   localparam logic [3:0] SPT_ADDR_COUNT = 4'h2;
   // timer_option_config fields
   localparam int SPT_OPT_CS_BIT = 5;
   localparam int SPT_OPT_EDGE_BIT = 4;
   localparam int SPT_OPT_PSA_BIT = 3;
   localparam int SPT_OPT_RATE_LSB = 0;
   localparam logic [7:0] SPT_OPT_IMPL_MASK = 8'h3f;
   // interrupt_control fields
   localparam int SPT_ICTL_EN_BIT = 5;
   localparam int SPT_ICTL_FLAG_BIT = 2;
   // reset values and other constants
   localparam logic [7:0] SPT_OPTION_RST = 8'h3f;
   localparam logic [7:0] SPT_COUNT_RST = 8'h00;
   localparam logic [7:0] SPT_COUNT_MAX = 8'hff;
   localparam logic [7:0] SPT_PSC_RST = 8'h00;
   localparam logic [7:0] SPT_WDT_RST = 8'h00;
   localparam logic [7:0] SPT_RDATA_RST = 8'h00;
   localparam logic [7:0] SPT_ONE8 = 8'h01;
   localparam logic SPT_PSA_TIMER = 1'b0;
   localparam logic SPT_CS_COUNTER = 1'b1;
   localparam logic SPT_EDGE_FALL = 1'b1;
   // watchdog base period in clk cycles, plain default
   localparam int SPT_WDT_BASE_DEFAULT = 1024;
   typedef enum logic [1:0] {
      SPT_Q1,
      SPT_Q2,
      SPT_Q3,
      SPT_Q4
   } spt_phase_t;
endpackage : spt_pkg
`default_nettype wire

//--- core/spt_timer.sv
// Overview of operation
// - one prescaler, owner chosen by assign bit
// - rate field picks 1:2 to 1:256 for timer, 1:1 to 1:128 for watchdog
// - timer gets 1:1 only under watchdog
// - prescaler count never software visible
// - timer count write clears prescaler when timer owns it
// - watchdog clear resets watchdog, and prescaler when watchdog owns it
// - ff to 00 rollover is the event
// - flag set on every rollover
// - only software clears the flag
// - irq needs flag and enable
// - timer frozen during sleep
// - counter input sampled on Q2, Q4
`default_nettype none
module spt_timer
   import spt_pkg::*;
#(
   parameter int WDT_BASE_CYCLES = SPT_WDT_BASE_DEFAULT
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [SPT_ADDR_W-1:0] reg_addr,
   input wire logic [SPT_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [SPT_DATA_W-1:0] reg_rdata,
   input wire logic watchdog_clear_instr,
   input wire logic sleep_mode,
   input wire logic timer_ext_clock_input,
   output logic timer_irq,
   output logic watchdog_timeout
);

   // divider mask: all ones in the low (rate + extra) bits
   function automatic logic [7:0] spt_div_mask(input logic [2:0] rate, input logic extra);
      logic [3:0] width;
      width = {1'b0, rate} + {3'b000, extra};
      spt_div_mask = 8'((9'h001 << width) - 9'h001);
   endfunction : spt_div_mask

   logic rst_meta_n;
   logic rst_sync_n;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   logic [7:0] option_reg;
   logic [7:0] count_reg;
   logic flag_reg;
   logic enable_reg;
   logic [7:0] psc_reg;
   logic [7:0] wdt_reg;
   logic [SPT_DATA_W-1:0] rdata_reg;
   spt_phase_t phase_reg;
   spt_phase_t phase_next;
   logic ext_meta_reg;
   logic ext_sync_reg;
   logic ext_prev_reg;
   logic pend_reg;
   logic [$clog2(WDT_BASE_CYCLES+1)-1:0] base_reg;
   logic timeout_reg;

   logic psa_wdt;
   logic [2:0] rate;
   logic wr_count;
   logic wr_option;
   logic wr_intctl;
   logic ext_edge;
   logic tmr_src;
   logic psc_in;
   logic psc_hit;
   logic psc_clear;
   logic tmr_raw;
   logic sample_phase;
   logic tmr_step;
   logic rollover;
   logic base_tick;
   logic wdt_in;

   assign wr_count = reg_wr && (reg_addr == SPT_ADDR_COUNT);
   assign wr_option = reg_wr && (reg_addr == SPT_ADDR_OPTION);
   assign wr_intctl = reg_wr && (reg_addr == SPT_ADDR_INTCTL);
   assign psa_wdt = (option_reg[SPT_OPT_PSA_BIT] != SPT_PSA_TIMER);
   assign rate = option_reg[SPT_OPT_RATE_LSB +: SPT_RATE_W];

   // instruction cycle phases
   always_comb begin
      case (phase_reg)
         SPT_Q1: phase_next = SPT_Q2;
         SPT_Q2: phase_next = SPT_Q3;
         SPT_Q3: phase_next = SPT_Q4;
         default: phase_next = SPT_Q1;
      endcase
   end
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         phase_reg <= SPT_Q1;
      end else begin
         phase_reg <= phase_next;
      end
   end

   // pin is asynchronous: two flops before use
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ext_meta_reg <= 1'b0;
         ext_sync_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
      end else begin
         ext_meta_reg <= timer_ext_clock_input;
         ext_sync_reg <= ext_meta_reg;
         ext_prev_reg <= ext_sync_reg;
      end
   end
   assign ext_edge = (option_reg[SPT_OPT_EDGE_BIT] == SPT_EDGE_FALL)
      ? (ext_prev_reg && !ext_sync_reg) : (!ext_prev_reg && ext_sync_reg);

   // one source step per instruction cycle in timer mode, one per selected pin edge in counter mode
   assign tmr_src = (option_reg[SPT_OPT_CS_BIT] == SPT_CS_COUNTER)
      ? ext_edge : (phase_reg == SPT_Q4);

   // watchdog base tick
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         base_reg <= '0;
      end else if (base_tick) begin
         base_reg <= '0;
      end else begin
         base_reg <= base_reg + 1'b1;
      end
   end
   assign base_tick = (base_reg == ($bits(base_reg))'(WDT_BASE_CYCLES - 1));

   assign psc_in = psa_wdt ? base_tick : (tmr_src && !sleep_mode);
   assign psc_hit = psc_in && ((psc_reg & spt_div_mask(rate, !psa_wdt))
      == spt_div_mask(rate, !psa_wdt));
   assign psc_clear = psa_wdt ? watchdog_clear_instr : wr_count;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         psc_reg <= SPT_PSC_RST;
      end else if (psc_clear) begin
         psc_reg <= SPT_PSC_RST;
      end else if (psc_in) begin
         psc_reg <= psc_reg + SPT_ONE8;
      end
   end

   assign tmr_raw = psa_wdt ? (tmr_src && !sleep_mode) : psc_hit;
   assign wdt_in = psa_wdt ? psc_hit : base_tick;

   // prescaler output taken on Q2 and Q4
   assign sample_phase = (phase_reg == SPT_Q2) || (phase_reg == SPT_Q4);
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pend_reg <= 1'b0;
      end else if (wr_count || sleep_mode) begin
         pend_reg <= 1'b0;
      end else if (tmr_raw) begin
         pend_reg <= 1'b1;
      end else if (sample_phase) begin
         pend_reg <= 1'b0;
      end
   end
   assign tmr_step = pend_reg && sample_phase && !sleep_mode && !wr_count;

   // software write beats a step in the same cycle
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         count_reg <= SPT_COUNT_RST;
      end else if (wr_count) begin
         count_reg <= reg_wdata;
      end else if (tmr_step) begin
         count_reg <= count_reg + SPT_ONE8;
      end
   end

   assign rollover = tmr_step && (count_reg == SPT_COUNT_MAX);

   // cleared only by software, set wins
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         flag_reg <= 1'b0;
      end else if (rollover) begin
         flag_reg <= 1'b1;
      end else if (wr_intctl && reg_wdata[SPT_ICTL_FLAG_BIT]) begin
         flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         option_reg <= SPT_OPTION_RST;
         enable_reg <= 1'b0;
      end else begin
         if (wr_option) begin
            option_reg <= reg_wdata & SPT_OPT_IMPL_MASK;
         end
         if (wr_intctl) begin
            enable_reg <= reg_wdata[SPT_ICTL_EN_BIT];
         end
      end
   end

   assign timer_irq = flag_reg && enable_reg;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         wdt_reg <= SPT_WDT_RST;
         timeout_reg <= 1'b0;
      end else begin
         timeout_reg <= !watchdog_clear_instr && wdt_in && (wdt_reg == SPT_COUNT_MAX);
         if (watchdog_clear_instr) begin
            wdt_reg <= SPT_WDT_RST;
         end else if (wdt_in) begin
            wdt_reg <= wdt_reg + SPT_ONE8;
         end
      end
   end
   assign watchdog_timeout = timeout_reg;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rdata_reg <= SPT_RDATA_RST;
      end else if (!reg_rd) begin
         rdata_reg <= SPT_RDATA_RST;
      end else if (reg_addr == SPT_ADDR_OPTION) begin
         rdata_reg <= option_reg;
      end else if (reg_addr == SPT_ADDR_INTCTL) begin
         rdata_reg <= 8'((32'(enable_reg) << SPT_ICTL_EN_BIT)
            | (32'(flag_reg) << SPT_ICTL_FLAG_BIT));
      end else if (reg_addr == SPT_ADDR_COUNT) begin
         rdata_reg <= count_reg;
      end else begin
         rdata_reg <= SPT_RDATA_RST;
      end
   end
   assign reg_rdata = rdata_reg;

   // checks
   a_psc_timer_clear: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      (wr_count && !psa_wdt) |=> (psc_reg == SPT_PSC_RST))
      else $error("prescaler not cleared by count write");

   a_psc_wdt_clear: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      (watchdog_clear_instr && psa_wdt) |=> (psc_reg == SPT_PSC_RST && wdt_reg == SPT_WDT_RST))
      else $error("watchdog clear missed prescaler or count");

   a_psc_owner_only: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      (psa_wdt && !base_tick && !watchdog_clear_instr && !wr_option)
      |=> $stable(psc_reg))
      else $error("prescaler moved without its owner");

   a_rate_lowest: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      (!psa_wdt && rate == 3'h0 && psc_in && !psc_clear && !psc_reg[0]) |-> !psc_hit)
      else $error("timer prescale below 1:2");

   a_undivided: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      (psa_wdt && tmr_src && !sleep_mode && !wr_count) |=> pend_reg)
      else $error("timer input divided under watchdog ownership");

   a_rollover_flag: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      (count_reg == SPT_COUNT_MAX && tmr_step) |=> (flag_reg && count_reg == SPT_COUNT_RST))
      else $error("rollover did not set flag");

   a_flag_sticky: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      (flag_reg && !(wr_intctl && reg_wdata[SPT_ICTL_FLAG_BIT])) |=> flag_reg)
      else $error("flag cleared without software");

   a_irq_cause: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      ((wr_intctl && !reg_wdata[SPT_ICTL_EN_BIT]) || (!flag_reg && !rollover))
      |=> !timer_irq)
      else $error("irq without flag and enable");

   a_sleep_freeze: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      (sleep_mode && !wr_count) |=> $stable(count_reg))
      else $error("timer moved during sleep");

   a_step_phase: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      (!wr_count && count_reg != $past(count_reg) && !$past(wr_count))
      |-> ($past(phase_reg) == SPT_Q2 || $past(phase_reg) == SPT_Q4))
      else $error("timer stepped outside Q2 or Q4");

   a_rd_unmapped: assert property (
      @(posedge clk) disable iff (!rst_sync_n)
      (reg_rd && reg_addr > SPT_ADDR_COUNT) |=> (reg_rdata == SPT_RDATA_RST))
      else $error("unmapped read not zero");

   c_rollover: cover property (@(posedge clk) disable iff (!rst_sync_n) rollover);
   c_irq: cover property (@(posedge clk) disable iff (!rst_sync_n) timer_irq);
   c_wdt_timeout: cover property (@(posedge clk) disable iff (!rst_sync_n) watchdog_timeout);
   c_set_clear_race: cover property (@(posedge clk) disable iff (!rst_sync_n)
      rollover && wr_intctl && reg_wdata[SPT_ICTL_FLAG_BIT]);

endmodule : spt_timer
`default_nettype wire

//--- tb/spt_timer_tb.sv
`default_nettype none
module tb
   import spt_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DOG_BASE = 8;
   localparam int LIMIT = 30000;
   typedef struct {
      logic [7:0] opt;
      int wait_cyc;
      logic [7:0] lo;
      logic [7:0] hi;
   } spt_tb_row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [SPT_ADDR_W-1:0] reg_addr = 4'h0;
   logic [SPT_DATA_W-1:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [SPT_DATA_W-1:0] reg_rdata;
   logic watchdog_clear_instr = 1'b0;
   logic sleep_mode = 1'b0;
   logic timer_ext_clock_input = 1'b0;
   logic timer_irq;
   logic watchdog_timeout;
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;
   int dog_pulses = 0;
   int p0 = 0;
   logic [7:0] rd_val;
   spt_tb_row_t rows [9];

   spt_timer #(.WDT_BASE_CYCLES(DOG_BASE)) i_spt_timer (
      .clk(clk),
      .rst_n(rst_n),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .watchdog_clear_instr(watchdog_clear_instr),
      .sleep_mode(sleep_mode),
      .timer_ext_clock_input(timer_ext_clock_input),
      .timer_irq(timer_irq),
      .watchdog_timeout(watchdog_timeout)
   );

   always #5 clk = ~clk;

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (watchdog_timeout === 1'b1) begin
         dog_pulses <= dog_pulses + 1;
      end
      if (cycles == LIMIT) begin
         failures = failures + 1;
         conclude();
      end
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude

   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask : step

   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk8

   task automatic chk_rng(input string name, input logic [7:0] lo, input logic [7:0] hi,
                          input logic [7:0] got);
      cmp_count = cmp_count + 1;
      if ((^got === 1'bx) || got < lo || got > hi) begin
         failures = failures + 1;
         $display("[ERR] %s expected %h..%h seen %h", name, lo, hi, got);
      end
   endtask : chk_rng

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask : rd

   task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string name);
      rd(a);
      chk8(name, exp, rd_val);
   endtask : rdchk

   task automatic dog_clear();
      @(posedge clk);
      watchdog_clear_instr <= 1'b1;
      @(posedge clk);
      watchdog_clear_instr <= 1'b0;
   endtask : dog_clear

   initial begin
      for (int i = 0; i < 8; i++) begin
         rows[i] = '{8'(i), 16 << (i + 1), 8'h03, 8'h04};
      end
      rows[8] = '{8'h08, 16, 8'h03, 8'h04};
      step(4);
      rst_n <= 1'b1;
      step(4);
      rdchk(SPT_ADDR_OPTION, 8'h3f, "option reset");
      // read data must be gone one cycle later
      step(1);
      #1 chk8("idle rdata", 8'h00, reg_rdata);
      rdchk(SPT_ADDR_INTCTL, 8'h00, "intctl reset");
      rdchk(SPT_ADDR_COUNT, 8'h00, "count reset");
      wr(4'h3, 8'hff);
      rdchk(4'h3, 8'h00, "unmapped"); // no hidden count readable
      chk8("irq reset", 8'h00, {7'h00, timer_irq});
      $display("test reset done");
      dog_clear();
      // phase of the first Q4 is unknown, so one step of slack
      foreach (rows[k]) begin
         wr(SPT_ADDR_OPTION, rows[k].opt);
         wr(SPT_ADDR_COUNT, 8'h00);
         step(rows[k].wait_cyc - 2);
         rd(SPT_ADDR_COUNT);
         chk_rng("rate count", rows[k].lo, rows[k].hi, rd_val);
      end
      $display("test rates done");
      wr(SPT_ADDR_OPTION, 8'hc8);
      rdchk(SPT_ADDR_OPTION, 8'h08, "option upper bits");
      wr(SPT_ADDR_COUNT, 8'hff);
      step(10);
      rdchk(SPT_ADDR_INTCTL, 8'h04, "flag on rollover");
      chk8("irq masked", 8'h00, {7'h00, timer_irq});
      rd(SPT_ADDR_COUNT);
      chk_rng("count wrapped", 8'h00, 8'h03, rd_val);
      step(40);
      rdchk(SPT_ADDR_INTCTL, 8'h04, "flag sticky");
      wr(SPT_ADDR_INTCTL, 8'h20);
      step(2);
      #1 chk8("irq enabled", 8'h01, {7'h00, timer_irq});
      rdchk(SPT_ADDR_INTCTL, 8'h24, "write zero keeps flag");
      wr(SPT_ADDR_INTCTL, 8'h24);
      step(2);
      #1 chk8("irq cleared", 8'h00, {7'h00, timer_irq});
      rdchk(SPT_ADDR_INTCTL, 8'h20, "flag cleared");
      $display("test overflow done");
      @(posedge clk);
      sleep_mode <= 1'b1;
      step(2);
      wr(SPT_ADDR_COUNT, 8'h10);
      step(40);
      rdchk(SPT_ADDR_COUNT, 8'h10, "frozen in sleep");
      @(posedge clk);
      sleep_mode <= 1'b0;
      step(20);
      rd(SPT_ADDR_COUNT);
      chk_rng("runs after sleep", 8'h12, 8'h17, rd_val);
      $display("test sleep done");
      dog_clear();
      wr(SPT_ADDR_OPTION, 8'h07);
      wr(SPT_ADDR_COUNT, 8'h00);
      step(900);
      wr(SPT_ADDR_COUNT, 8'h00);
      step(900);
      rdchk(SPT_ADDR_COUNT, 8'h00, "prescaler cleared");
      $display("test prescaler clear done");
      // safe hand-over of the prescaler to the watchdog
      dog_clear();
      wr(SPT_ADDR_COUNT, 8'h00);
      wr(SPT_ADDR_OPTION, 8'h0f);
      dog_clear();
      // rising edges first, then falling edges
      for (int m = 0; m < 2; m++) begin
         wr(SPT_ADDR_OPTION, (m == 0) ? 8'h28 : 8'h38);
         wr(SPT_ADDR_COUNT, 8'h00);
         repeat (5) begin
            timer_ext_clock_input <= 1'b1;
            step(6);
            timer_ext_clock_input <= 1'b0;
            step(6);
         end
         step(8);
         rdchk(SPT_ADDR_COUNT, 8'h05, "pin edges");
      end
      $display("test counter done");
      // timeout expected 256 steps of 16 cycles after each clear
      wr(SPT_ADDR_OPTION, 8'h09);
      dog_clear();
      step(2);
      p0 = dog_pulses;
      step(3000);
      dog_clear();
      step(3000);
      chk8("no timeout", 8'h00, 8'(dog_pulses - p0));
      step(1200);
      chk8("one timeout", 8'h01, 8'(dog_pulses - p0));
      $display("test watchdog done");
      rst_n <= 1'b0;
      step(3);
      rst_n <= 1'b1;
      step(4);
      rdchk(SPT_ADDR_OPTION, 8'h3f, "option second reset");
      rdchk(SPT_ADDR_COUNT, 8'h00, "count second reset");
      $display("test second reset done");
      conclude();
   end
endmodule : tb
`default_nettype wire
